// ### logic/oms_sequencer.sv
// module: operating mode sequencer, top level
`timescale 1ns/10ps
module oms_sequencer #(
    parameter int STARTUP_CYCLES = oms_pkg::STARTUP_CYCLES,
    parameter int IDLE_CYCLES = oms_pkg::IDLE_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // supply monitor and pins
    input wire logic por_clear_i,
    input wire logic hw_gate_i,
    input wire logic thermal_trip_i,
    // register writes from the serial interface
    input wire oms_pkg::oms_wr_t wr_i,
    // look-ahead idle hint and pwm demand from the engines
    input wire logic pwm_idle_i,
    input wire logic pwm_demand_i,
    // status
    output oms_pkg::oms_mode_t mode_o,
    output logic run_bit_o,
    output logic [7:0] ctrl_o,
    output logic [7:0] misc_o,
    output logic wr_accept_o,
    // power controls
    output oms_pkg::oms_pwr_t pwr_o
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic por_s;
    logic gate_s;
    logic trip_s;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 3'h1;
            pin_sync <= 3'h1;
        end else begin
            pin_meta <= {thermal_trip_i, hw_gate_i, por_clear_i};
            pin_sync <= pin_meta;
        end
    end

    assign por_s = pin_sync[0];
    assign gate_s = pin_sync[1];
    assign trip_s = pin_sync[2];

    // ----------------------------------------------------------------
    // software reset and register file
    // ----------------------------------------------------------------
    logic sw_reset;
    logic reg_clear;
    logic wr_ok;
    oms_pkg::oms_mode_t mode;

    // other values are simply ignored
    assign sw_reset = wr_i.en && wr_i.addr == oms_pkg::SW_RESET_ADDR
        && wr_i.data == oms_pkg::SW_RESET_KEY;
    assign reg_clear = por_s || sw_reset || mode == oms_pkg::OMS_RESET;
    // standby takes writes only with the gate high; a pending clear wins
    assign wr_ok = gate_s && !por_s
        && mode != oms_pkg::OMS_RESET;
    assign wr_accept_o = wr_ok;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_o <= oms_pkg::CTRL_RESET;
        end else if (reg_clear) begin
            ctrl_o <= oms_pkg::CTRL_RESET;
        end else if (wr_ok && wr_i.en && wr_i.addr == oms_pkg::CTRL_ADDR) begin
            ctrl_o <= wr_i.data;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            misc_o <= oms_pkg::MISC_RESET;
        end else if (reg_clear) begin
            misc_o <= oms_pkg::MISC_RESET;
        end else if (wr_ok && wr_i.en && wr_i.addr == oms_pkg::MISC_ADDR) begin
            misc_o <= wr_i.data;
        end
    end

    logic run_bit;
    logic ps_allow;
    assign run_bit = ctrl_o[oms_pkg::CTRL_RUN_BIT];
    assign ps_allow = misc_o[oms_pkg::MISC_PS_BIT];
    assign run_bit_o = run_bit;

    // ----------------------------------------------------------------
    // startup, idle and wake-up timers
    // ----------------------------------------------------------------
    logic start_load;
    logic start_done;
    logic idle_load;
    logic idle_done;
    logic wake_load;
    logic wake_done;

    oms_timer #(.WIDTH(32)) u_start (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .load_i(start_load),
        .count_i(32'(STARTUP_CYCLES - 1)),
        .run_i(mode == oms_pkg::OMS_STARTUP && !trip_s),
        .done_o(start_done)
    );

    // idle window restarts on any pwm activity hint
    oms_timer #(.WIDTH(32)) u_idle (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .load_i(idle_load),
        .count_i(32'(IDLE_CYCLES)),
        .run_i(1'b1),
        .done_o(idle_done)
    );
    assign idle_load = !pwm_idle_i || pwm_demand_i
        || mode != oms_pkg::OMS_NORMAL;

    // short wake-up, much faster than a full startup
    oms_timer #(.WIDTH(32)) u_wake (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .load_i(wake_load),
        .count_i(32'(oms_pkg::WAKE_CYCLES - 1)),
        .run_i(1'b1),
        .done_o(wake_done)
    );

    // ----------------------------------------------------------------
    // mode state machine
    // ----------------------------------------------------------------
    oms_pkg::oms_mode_t next_mode;
    logic waking;
    logic next_waking;

    always_comb begin
        next_mode = mode;
        next_waking = waking;
        case (mode)
            oms_pkg::OMS_RESET: begin
                if (!por_s && !sw_reset) begin
                    next_mode = oms_pkg::OMS_STANDBY;
                end
            end
            oms_pkg::OMS_STANDBY: begin
                if (run_bit && gate_s) begin
                    next_mode = oms_pkg::OMS_STARTUP;
                end
            end
            oms_pkg::OMS_STARTUP: begin
                // thermal trip freezes the delay
                if (start_done && !trip_s) begin
                    next_mode = oms_pkg::OMS_NORMAL;
                end
            end
            oms_pkg::OMS_NORMAL: begin
                if (ps_allow && idle_done) begin
                    next_mode = oms_pkg::OMS_SAVE;
                end
            end
            oms_pkg::OMS_SAVE: begin
                if (!ps_allow || pwm_demand_i) begin
                    next_waking = 1'b1;
                end
                if (waking && wake_done) begin
                    next_mode = oms_pkg::OMS_NORMAL;
                    next_waking = 1'b0;
                end
            end
            default: begin
                next_mode = oms_pkg::OMS_RESET;
            end
        endcase
        if (trip_s && mode != oms_pkg::OMS_RESET
            && mode != oms_pkg::OMS_STANDBY) begin
            next_mode = oms_pkg::OMS_STARTUP;
            next_waking = 1'b0;
        end
        if (mode != oms_pkg::OMS_RESET && (!run_bit || !gate_s)) begin
            next_mode = oms_pkg::OMS_STANDBY;
            next_waking = 1'b0;
        end
        if (por_s || sw_reset) begin
            next_mode = oms_pkg::OMS_RESET;
            next_waking = 1'b0;
        end
    end

    assign start_load = mode != oms_pkg::OMS_STARTUP;
    assign wake_load = !waking;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mode <= oms_pkg::OMS_RESET;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            waking <= 1'b0;
        end else begin
            waking <= next_waking;
        end
    end

    assign mode_o = mode;

    // ----------------------------------------------------------------
    // power controls
    // ----------------------------------------------------------------
    // core stays on in power-save so execution and wake-up continue
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pwr_o <= '0;
        end else begin
            pwr_o.ref_bias_osc_en <= next_mode == oms_pkg::OMS_STARTUP
                || next_mode == oms_pkg::OMS_NORMAL
                || next_mode == oms_pkg::OMS_SAVE;
            pwr_o.analog_en <= next_mode == oms_pkg::OMS_NORMAL
                || (next_mode == oms_pkg::OMS_SAVE && next_waking);
            pwr_o.core_en <= next_mode == oms_pkg::OMS_NORMAL
                || next_mode == oms_pkg::OMS_SAVE;
        end
    end
endmodule

// ### logic/oms_pkg.sv
// package: constants and types for the operating mode sequencer
package oms_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] SW_RESET_ADDR = 8'h3D;
    localparam logic [7:0] SW_RESET_KEY = 8'hFF;
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] MISC_ADDR = 8'h36;
    localparam int CTRL_RUN_BIT = 6;
    localparam int MISC_PS_BIT = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MISC_RESET = 8'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int STARTUP_US = 500;
    localparam int STARTUP_CYCLES = STARTUP_US * CLK_MHZ;
    localparam int IDLE_MS = 50;
    localparam int IDLE_CYCLES = IDLE_MS * 1000 * CLK_MHZ;
    localparam int WAKE_CYCLES = 16;

    typedef enum logic [2:0] {
        OMS_RESET = 3'h0,
        OMS_STANDBY = 3'h1,
        OMS_STARTUP = 3'h2,
        OMS_NORMAL = 3'h3,
        OMS_SAVE = 3'h4
    } oms_mode_t;

    // register write strobe from the serial interface
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } oms_wr_t;

    // power controls toward the analog blocks
    typedef struct packed {
        logic ref_bias_osc_en;
        logic analog_en;
        logic core_en;
    } oms_pwr_t;

endpackage

// ### logic/oms_timer.sv
// module: loadable down counter that flags expiry
`timescale 1ns/10ps
module oms_timer #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic load_i,
    input wire logic [WIDTH-1:0] count_i,
    input wire logic run_i,
    // status
    output logic done_o
);
    logic [WIDTH-1:0] remain;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            remain <= '0;
        end else if (load_i) begin
            remain <= count_i;
        end else if (run_i && remain != '0) begin
            remain <= remain - 1'b1;
        end
    end

    assign done_o = (remain == '0) && !load_i;
endmodule

// ### tb/oms_checker.sv
// checker: port assertions for the operating mode sequencer
`timescale 1ns/10ps
module oms_checker #(
    parameter int STARTUP_CYCLES = 20
) (
    // clock, reset and inputs
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic por_clear_i,
    input wire logic thermal_trip_i,
    input wire oms_pkg::oms_wr_t wr_i,
    input wire logic pwm_demand_i,
    // outputs
    input wire oms_pkg::oms_mode_t mode_o,
    input wire logic run_bit_o,
    input wire logic [7:0] ctrl_o,
    input wire logic [7:0] misc_o,
    input wire logic wr_accept_o,
    input wire oms_pkg::oms_pwr_t pwr_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    int st_cnt;
    // consecutive cycles spent in startup
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_cnt <= 0;
        end else if (mode_o == oms_pkg::OMS_STARTUP) begin
            st_cnt <= st_cnt + 1;
        end else begin
            st_cnt <= 0;
        end
    end
    // ----
    // properties
    // ----
    property p_swrst;
        wr_i.en && wr_i.addr == oms_pkg::SW_RESET_ADDR
            && wr_i.data == oms_pkg::SW_RESET_KEY
            |=> mode_o == oms_pkg::OMS_RESET;
    endproperty
    a_swrst: assert property (p_swrst) else $error("no sw reset");
    property p_por;
        por_clear_i [*4] |-> mode_o == oms_pkg::OMS_RESET;
    endproperty
    a_por: assert property (p_por) else $error("por not held");
    property p_run0;
        mode_o == oms_pkg::OMS_RESET |=> !run_bit_o;
    endproperty
    a_run0: assert property (p_run0) else $error("run bit set");
    property p_stby;
        mode_o == oms_pkg::OMS_STANDBY |-> pwr_o == 3'h0;
    endproperty
    a_stby: assert property (p_stby) else $error("standby powered");
    property p_ctrl;
        wr_accept_o && wr_i.en && wr_i.addr == oms_pkg::CTRL_ADDR
            |=> ctrl_o == $past(wr_i.data);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl not taken");
    property p_ref;
        mode_o == oms_pkg::OMS_STARTUP |-> pwr_o.ref_bias_osc_en;
    endproperty
    a_ref: assert property (p_ref) else $error("ref off");
    property p_len;
        mode_o == oms_pkg::OMS_NORMAL
            && $past(mode_o) == oms_pkg::OMS_STARTUP
            |-> st_cnt >= STARTUP_CYCLES - 1;
    endproperty
    a_len: assert property (p_len) else $error("startup short");
    property p_trip;
        thermal_trip_i [*4] |-> mode_o != oms_pkg::OMS_NORMAL
            && mode_o != oms_pkg::OMS_SAVE;
    endproperty
    a_trip: assert property (p_trip) else $error("runs hot");
    // analog comes back during the fast wake-up, so judge on entry
    property p_save;
        mode_o == oms_pkg::OMS_SAVE && $past(mode_o) != oms_pkg::OMS_SAVE
            |-> !pwr_o.analog_en && $past(misc_o[oms_pkg::MISC_PS_BIT]);
    endproperty
    a_save: assert property (p_save) else $error("bad save");
    property p_wake;
        mode_o == oms_pkg::OMS_SAVE && pwm_demand_i
            |-> ##[1:20] mode_o != oms_pkg::OMS_SAVE;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    c_save: cover property (mode_o == oms_pkg::OMS_SAVE);
    c_trip: cover property (thermal_trip_i [*4]);
    c_swrst: cover property (p_swrst);
endmodule
bind oms_sequencer oms_checker #(.STARTUP_CYCLES(STARTUP_CYCLES))
    u_oms_checker (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .por_clear_i(por_clear_i), .thermal_trip_i(thermal_trip_i),
    .wr_i(wr_i), .pwm_demand_i(pwm_demand_i), .mode_o(mode_o),
    .run_bit_o(run_bit_o), .ctrl_o(ctrl_o), .misc_o(misc_o),
    .wr_accept_o(wr_accept_o), .pwr_o(pwr_o));

// ### tb/oms_host_model.sv
// partner: host side writer on the register write strobe
`timescale 1ns/10ps
module oms_host_model (
    // clock
    input wire logic ref_clk_i,
    // write strobe
    output oms_pkg::oms_wr_t wr_o
);
    initial wr_o = '0;
    // single byte, strobe high one cycle; lines flip once released
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        wr_o <= '{en: 1'b1, addr: a, data: d};
        @(posedge ref_clk_i);
        wr_o <= '{en: 1'b0, addr: ~a, data: ~d};
    endtask
endmodule

// ### tb/oms_sequencer_tb.sv
// testbench: mode sequencer scenarios
`timescale 1ns/10ps
`define CHK(a, b) \
    samples_checked++; \
    if ((a) !== (b)) begin \
        n_mismatch++; \
        $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); \
    end
module oms_sequencer_tb;
    localparam int ST = 20;
    localparam int IDLE = 50;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic por_clear_i = 1'b1;
    logic hw_gate_i = 1'b0;
    logic thermal_trip_i = 1'b0;
    logic pwm_idle_i = 1'b0;
    logic pwm_demand_i = 1'b0;
    oms_pkg::oms_wr_t wr_i;
    oms_pkg::oms_mode_t mode_o;
    logic run_bit_o;
    logic [7:0] ctrl_o;
    logic [7:0] misc_o;
    oms_pkg::oms_pwr_t pwr_o;
    logic wr_accept_o;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    oms_sequencer #(.STARTUP_CYCLES(ST), .IDLE_CYCLES(IDLE))
        u_oms_sequencer (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .por_clear_i(por_clear_i), .hw_gate_i(hw_gate_i),
        .thermal_trip_i(thermal_trip_i), .wr_i(wr_i),
        .pwm_idle_i(pwm_idle_i), .pwm_demand_i(pwm_demand_i),
        .mode_o(mode_o), .run_bit_o(run_bit_o), .ctrl_o(ctrl_o),
        .misc_o(misc_o), .wr_accept_o(wr_accept_o), .pwr_o(pwr_o));
    oms_host_model u_oms_host_model (.ref_clk_i(ref_clk_i), .wr_o(wr_i));
    // ----
    // helpers
    // ----
    task automatic finish_test;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wait_mode(input oms_pkg::oms_mode_t m, input int n);
        repeat (n) begin
            @(negedge ref_clk_i);
            if (mode_o === m) break;
        end
    endtask
    task automatic t_por;
        repeat (4) @(negedge ref_clk_i);
        `CHK(mode_o, oms_pkg::OMS_RESET)
        `CHK(run_bit_o, 1'b0)
        @(posedge ref_clk_i) por_clear_i <= 1'b0;
        wait_mode(oms_pkg::OMS_STANDBY, 8);
        `CHK(mode_o, oms_pkg::OMS_STANDBY)
        `CHK(pwr_o, 3'h0)
        `CHK(wr_accept_o, 1'b0)
    endtask
    task automatic t_start;
        u_oms_host_model.write(oms_pkg::CTRL_ADDR, 8'h40);
        @(negedge ref_clk_i);
        `CHK(ctrl_o, 8'h00)
        `CHK(mode_o, oms_pkg::OMS_STANDBY)
        @(posedge ref_clk_i) hw_gate_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        u_oms_host_model.write(oms_pkg::CTRL_ADDR, 8'h40);
        wait_mode(oms_pkg::OMS_STARTUP, 6);
        `CHK(mode_o, oms_pkg::OMS_STARTUP)
        `CHK(pwr_o.ref_bias_osc_en, 1'b1)
        `CHK(run_bit_o, 1'b1)
        `CHK(wr_accept_o, 1'b1)
        repeat (ST - 3) @(negedge ref_clk_i);
        `CHK(mode_o, oms_pkg::OMS_STARTUP)
        wait_mode(oms_pkg::OMS_NORMAL, 8);
        `CHK(mode_o, oms_pkg::OMS_NORMAL)
        `CHK(pwr_o.core_en, 1'b1)
    endtask
    task automatic t_trip;
        @(posedge ref_clk_i) thermal_trip_i <= 1'b1;
        wait_mode(oms_pkg::OMS_STARTUP, 6);
        repeat (2 * ST) @(negedge ref_clk_i);
        `CHK(mode_o, oms_pkg::OMS_STARTUP)
        @(posedge ref_clk_i) thermal_trip_i <= 1'b0;
        wait_mode(oms_pkg::OMS_NORMAL, ST + 8);
        `CHK(mode_o, oms_pkg::OMS_NORMAL)
    endtask
    task automatic t_save;
        @(posedge ref_clk_i) pwm_idle_i <= 1'b1;
        repeat (IDLE + 10) @(negedge ref_clk_i);
        `CHK(mode_o, oms_pkg::OMS_NORMAL)
        @(posedge ref_clk_i) pwm_idle_i <= 1'b0;
        u_oms_host_model.write(oms_pkg::MISC_ADDR, 8'h20);
        @(posedge ref_clk_i) pwm_idle_i <= 1'b1;
        repeat (IDLE - 5) @(negedge ref_clk_i);
        `CHK(mode_o, oms_pkg::OMS_NORMAL)
        wait_mode(oms_pkg::OMS_SAVE, 20);
        `CHK(mode_o, oms_pkg::OMS_SAVE)
        `CHK(pwr_o.analog_en, 1'b0)
        @(posedge ref_clk_i);
        pwm_idle_i <= 1'b0;
        pwm_demand_i <= 1'b1;
        @(posedge ref_clk_i) pwm_demand_i <= 1'b0;
        wait_mode(oms_pkg::OMS_NORMAL, 22);
        `CHK(mode_o, oms_pkg::OMS_NORMAL)
        `CHK(pwr_o.analog_en, 1'b1)
    endtask
    task automatic t_swrst;
        u_oms_host_model.write(oms_pkg::SW_RESET_ADDR, 8'h7F);
        repeat (3) @(negedge ref_clk_i);
        `CHK(mode_o, oms_pkg::OMS_NORMAL)
        `CHK(ctrl_o, 8'h40)
        u_oms_host_model.write(oms_pkg::SW_RESET_ADDR, 8'hFF);
        @(negedge ref_clk_i);
        `CHK(mode_o, oms_pkg::OMS_RESET)
        wait_mode(oms_pkg::OMS_STANDBY, 4);
        `CHK({ctrl_o, misc_o}, 16'h0000)
        u_oms_host_model.write(oms_pkg::CTRL_ADDR, 8'h40);
        wait_mode(oms_pkg::OMS_STARTUP, 4);
        `CHK(mode_o, oms_pkg::OMS_STARTUP)
        @(posedge ref_clk_i) hw_gate_i <= 1'b0;
        wait_mode(oms_pkg::OMS_STANDBY, 6);
        `CHK(mode_o, oms_pkg::OMS_STANDBY)
        `CHK(pwr_o, 3'h0)
        `CHK(wr_accept_o, 1'b0)
    endtask
    // cut a hang short
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        t_por();
        t_start();
        t_trip();
        t_save();
        t_swrst();
        finish_test();
    end
endmodule
